/* File: include/asfs_pkg.sv */
`default_nettype none
package asfs_pkg;
  localparam int ASFS_DIV_W      = 8;
  localparam int ASFS_FIFO_DEPTH = 16;

  // base clocks per serial bit
  localparam logic [4:0] ASFS_OS_NORMAL = 5'h10;
  localparam logic [4:0] ASFS_OS_FAST   = 5'h08;

  // clock-enable field codes
  localparam logic [1:0] ASFS_CKE_INTERNAL = 2'h0;
  localparam logic [1:0] ASFS_CKE_CLKOUT   = 2'h1;

  // bit periods the settle counter waits after a setup load
  localparam logic [1:0] ASFS_SETTLE_BITS = 2'h2;

  // status flag positions
  localparam int ASFS_FLG_W       = 4;
  localparam int ASFS_FLG_RXERR   = 0;
  localparam int ASFS_FLG_READY   = 1;
  localparam int ASFS_FLG_BREAK   = 2;
  localparam int ASFS_FLG_OVERRUN = 3;

  typedef struct packed {
    logic [1:0]            clock_enable_sel;
    logic                  sync_select;
    logic                  char_length_a;
    logic                  char_length_b;
    logic                  parity_enable;
    logic                  parity_odd;
    logic                  stop_two;
    logic                  multi_drop_enable;
    logic [1:0]            prescale_select;
    logic                  card_interface_select;
    logic                  data_invert;
    logic                  bit_order;
    logic                  oversample_select;
    logic                  noise_filter_enable;
    logic                  generator_double_speed;
    logic                  simple_two_wire_mode;
    logic                  clock_phase;
    logic                  clock_polarity;
    logic [ASFS_DIV_W-1:0] bit_rate_divisor;
  } asfs_cfg_t;

  localparam asfs_cfg_t ASFS_CFG_RST = '{
    clock_enable_sel:       2'h0,
    sync_select:            1'h0,
    char_length_a:          1'h0,
    char_length_b:          1'h1,
    parity_enable:          1'h0,
    parity_odd:             1'h0,
    stop_two:               1'h0,
    multi_drop_enable:      1'h0,
    prescale_select:        2'h0,
    card_interface_select:  1'h0,
    data_invert:            1'h0,
    bit_order:              1'h0,
    oversample_select:      1'h1,
    noise_filter_enable:    1'h0,
    generator_double_speed: 1'h0,
    simple_two_wire_mode:   1'h0,
    clock_phase:            1'h0,
    clock_polarity:         1'h0,
    bit_rate_divisor:       8'hFF
  };

  typedef struct packed {
    logic       mp_bit;
    logic [8:0] data;
  } asfs_word_t;

  typedef enum logic [2:0] {
    ASFS_IDLE   = 3'h0,
    ASFS_START  = 3'h1,
    ASFS_DATA   = 3'h2,
    ASFS_PARITY = 3'h3,
    ASFS_MPB    = 3'h4,
    ASFS_STOP   = 3'h5
  } asfs_state_t;
endpackage
`default_nettype wire

/* File: verilog/asfs_fifo.sv */
`default_nettype none
module asfs_fifo
  import asfs_pkg::*;
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = ASFS_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];

  // index wrap written out so a depth that is not a power of two works
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce && push) mem_q[wr_q] <= in_data;
  end
endmodule
`default_nettype wire

/* File: verilog/asfs_baud_gen.sv */
`default_nettype none
module asfs_baud_gen
  import asfs_pkg::*;
#(
  parameter int DIV_W = ASFS_DIV_W
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  // rate setup
  input  wire logic [1:0]       prescale_select,
  input  wire logic             double_speed,
  input  wire logic [DIV_W-1:0] divisor,
  // one pulse per base clock period
  output logic                  tick
);
  localparam int CNT_W = DIV_W + 7;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] full_len;
  logic [CNT_W-1:0] limit;

  // prescale 00 feeds the undivided clock, others divide by 4, 16, 64
  assign full_len = CNT_W'({1'b0, divisor} + 1'b1) << {prescale_select, 1'b0};
  assign limit    = (double_speed && full_len > 1) ? full_len >> 1 : full_len;
  // >= so a smaller divisor loaded mid-count cannot run the counter away
  assign tick     = cnt_q >= limit - CNT_W'(1);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) cnt_q <= '0;
    else if (ce) cnt_q <= tick ? '0 : cnt_q + 1'b1;
  end
endmodule
`default_nettype wire

/* File: verilog/asfs_serial.sv */
`default_nettype none
module asfs_serial
  import asfs_pkg::*;
#(
  parameter int FIFO_DEPTH = ASFS_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  input  wire logic                  ce,
  // setup
  input  wire logic                  cfg_load,
  input  wire asfs_cfg_t             cfg_in,
  input  wire logic                  transmit_enable,
  input  wire logic                  receive_enable,
  output asfs_cfg_t                  cfg_active,
  output logic                       divisor_settled,
  output logic                       mode_unsupported,
  // transmit stream
  input  wire logic                  tx_valid,
  output logic                       tx_ready,
  input  wire asfs_word_t            tx_word,
  // receive stream
  output logic                       rx_valid,
  input  wire logic                  rx_ready,
  output asfs_word_t                 rx_word,
  // status flags
  input  wire logic                  flag_read,
  input  wire logic                  flag_write,
  input  wire logic [ASFS_FLG_W-1:0] flag_wdata,
  output logic [ASFS_FLG_W-1:0]      flags,
  // serial pins
  output logic                       txd,
  input  wire logic                  rxd,
  output logic                       serial_clock_pin_o,
  output logic                       serial_clock_pin_oe
);
  function automatic logic [3:0] data_bits(input asfs_cfg_t c);
    if (!c.char_length_b) return 4'h9;
    return c.char_length_a ? 4'h7 : 4'h8;
  endfunction

  function automatic logic [3:0] bit_index(input asfs_cfg_t c, input logic [3:0] k);
    logic [3:0] n;
    n = data_bits(c);
    return c.bit_order ? 4'(n - 4'h1 - k) : k;
  endfunction

  function automatic logic parity_of(input asfs_cfg_t c, input logic [8:0] d);
    logic [8:0] mask;
    mask = 9'h1FF >> (4'h9 - data_bits(c));
    return (^(d & mask)) ^ c.parity_odd;
  endfunction

  function automatic asfs_state_t after_bit(input asfs_cfg_t c, input asfs_state_t s);
    if (s == ASFS_DATA && c.parity_enable) return ASFS_PARITY;
    if (s != ASFS_MPB && c.multi_drop_enable) return ASFS_MPB;
    return ASFS_STOP;
  endfunction

  // setup and timing
  asfs_cfg_t             cfg_q;
  logic                  tick;
  logic [4:0]            os_len;
  logic [4:0]            half;
  logic [3:0]            nbits;
  logic                  mode_ok;
  logic [4:0]            bclk_q;
  logic                  bclk_end;
  logic [1:0]            settle_q;
  logic                  sck_q;
  logic                  sck_oe_q;

  assign os_len  = cfg_q.oversample_select ? ASFS_OS_FAST : ASFS_OS_NORMAL;
  assign half    = os_len >> 1;
  assign nbits   = data_bits(cfg_q);
  // only the asynchronous, internally clocked serial mode is built
  assign mode_ok = !cfg_q.sync_select && !cfg_q.card_interface_select
                 && !cfg_q.simple_two_wire_mode && !cfg_q.clock_enable_sel[1];
  assign bclk_end         = tick && bclk_q == os_len - 5'h1;
  assign divisor_settled  = settle_q == ASFS_SETTLE_BITS;
  assign mode_unsupported = !mode_ok;
  assign cfg_active       = cfg_q;

  asfs_baud_gen #(
    .DIV_W (ASFS_DIV_W)
  ) u_baud (
    .ref_clk         (ref_clk),
    .rstn            (rstn),
    .ce              (ce),
    .prescale_select (cfg_q.prescale_select),
    .double_speed    (cfg_q.generator_double_speed),
    .divisor         (cfg_q.bit_rate_divisor),
    .tick            (tick)
  );

  // first bit after a load may be partial, so two boundaries make one full bit
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q    <= ASFS_CFG_RST;
      bclk_q   <= '0;
      settle_q <= '0;
    end else if (ce) begin
      if (cfg_load) cfg_q <= cfg_in;
      if (tick) bclk_q <= bclk_end ? '0 : bclk_q + 5'h1;
      if (cfg_load) settle_q <= '0;
      else if (bclk_end && !divisor_settled) settle_q <= settle_q + 2'h1;
    end
  end

  // pin clock leaves the block only under the clock-out code
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sck_q    <= 1'b0;
      sck_oe_q <= 1'b0;
    end else if (ce) begin
      sck_q    <= bclk_q < half;
      sck_oe_q <= mode_ok && cfg_q.clock_enable_sel == ASFS_CKE_CLKOUT;
    end
  end

  assign serial_clock_pin_o  = sck_q;
  assign serial_clock_pin_oe = sck_oe_q;

  // transmit side
  logic        fifo_valid;
  logic        fifo_pop;
  asfs_word_t  fifo_word;
  asfs_state_t tx_state_q;
  asfs_state_t tx_state_d;
  asfs_word_t  tx_word_q;
  logic [4:0]  tx_cnt_q;
  logic [3:0]  tx_k_q;
  logic        tx_bit_end;
  logic        tx_start;
  logic        tx_line;
  logic        txd_q;

  asfs_fifo #(
    .WIDTH ($bits(asfs_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .ce        (ce),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_word),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_word)
  );

  assign tx_start   = tx_state_q == ASFS_IDLE && fifo_valid && transmit_enable
                    && mode_ok && divisor_settled;
  assign fifo_pop   = tx_start;
  assign tx_bit_end = tick && tx_cnt_q == os_len - 5'h1;

  always_comb begin
    tx_state_d = tx_state_q;
    case (tx_state_q)
      ASFS_IDLE:   if (tx_start) tx_state_d = ASFS_START;
      ASFS_START:  if (tx_bit_end) tx_state_d = ASFS_DATA;
      ASFS_DATA:   if (tx_bit_end && tx_k_q == nbits - 4'h1) tx_state_d = after_bit(cfg_q, ASFS_DATA);
      ASFS_PARITY: if (tx_bit_end) tx_state_d = after_bit(cfg_q, ASFS_PARITY);
      ASFS_MPB:    if (tx_bit_end) tx_state_d = ASFS_STOP;
      ASFS_STOP: begin
        if (tx_bit_end && (!cfg_q.stop_two || tx_k_q == 4'h1)) tx_state_d = ASFS_IDLE;
      end
      default:     tx_state_d = ASFS_IDLE;
    endcase
    // dropping the enable aborts the frame and returns the line to mark
    if (!transmit_enable) tx_state_d = ASFS_IDLE;
  end

  always_comb begin
    case (tx_state_q)
      ASFS_START:  tx_line = 1'b0;
      ASFS_DATA:   tx_line = tx_word_q.data[bit_index(cfg_q, tx_k_q)] ^ cfg_q.data_invert;
      ASFS_PARITY: tx_line = parity_of(cfg_q, tx_word_q.data) ^ cfg_q.data_invert;
      ASFS_MPB:    tx_line = tx_word_q.mp_bit;
      default:     tx_line = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_state_q <= ASFS_IDLE;
      tx_word_q  <= '0;
      tx_cnt_q   <= '0;
      tx_k_q     <= '0;
      txd_q      <= 1'b1;
    end else if (ce) begin
      tx_state_q <= tx_state_d;
      if (tx_start) tx_word_q <= fifo_word;
      if (tx_state_d != tx_state_q) tx_cnt_q <= '0;
      else if (tick) tx_cnt_q <= tx_bit_end ? '0 : tx_cnt_q + 5'h1;
      if (tx_state_d != tx_state_q) tx_k_q <= '0;
      else if (tx_bit_end) tx_k_q <= tx_k_q + 4'h1;
      txd_q <= transmit_enable ? tx_line : 1'b1;
    end
  end

  assign txd = txd_q;

  // receive side
  logic [2:0]  nf_q;
  logic        nf_major;
  logic        rx_in;
  asfs_state_t rx_state_q;
  asfs_state_t rx_state_d;
  logic [4:0]  rx_cnt_q;
  logic [3:0]  rx_k_q;
  logic [8:0]  rx_data_q;
  logic        rx_par_q;
  logic        rx_mp_q;
  logic        rx_high_q;
  logic        rx_sample;
  logic        rx_done;
  logic        rx_perr;
  logic        rx_ferr;
  logic        hold_q;
  asfs_word_t  rx_word_q;
  logic        rx_store;
  logic        rx_pop;

  // three-sample majority on the base clock rejects glitches shorter than one base clock
  assign nf_major  = (nf_q[0] & nf_q[1]) | (nf_q[1] & nf_q[2]) | (nf_q[0] & nf_q[2]);
  assign rx_in     = cfg_q.noise_filter_enable ? nf_major : rxd;
  assign rx_sample = tick && (rx_state_q == ASFS_START ? rx_cnt_q == half - 5'h1
                                                       : rx_cnt_q == os_len - 5'h1);
  assign rx_done   = rx_state_q == ASFS_STOP && rx_sample;
  assign rx_perr   = cfg_q.parity_enable && rx_par_q != parity_of(cfg_q, rx_data_q);
  assign rx_ferr   = !rx_in;
  assign rx_pop    = hold_q && rx_ready;
  // a full holding word is overrun, not overwritten
  assign rx_store  = rx_done && (!hold_q || rx_ready);

  always_comb begin
    rx_state_d = rx_state_q;
    case (rx_state_q)
      ASFS_IDLE:   if (tick && !rx_in) rx_state_d = ASFS_START;
      ASFS_START:  if (rx_sample) rx_state_d = rx_in ? ASFS_IDLE : ASFS_DATA;
      ASFS_DATA:   if (rx_sample && rx_k_q == nbits - 4'h1) rx_state_d = after_bit(cfg_q, ASFS_DATA);
      ASFS_PARITY: if (rx_sample) rx_state_d = after_bit(cfg_q, ASFS_PARITY);
      ASFS_MPB:    if (rx_sample) rx_state_d = ASFS_STOP;
      ASFS_STOP:   if (rx_sample) rx_state_d = ASFS_IDLE;
      default:     rx_state_d = ASFS_IDLE;
    endcase
    if (!receive_enable || !mode_ok) rx_state_d = ASFS_IDLE;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      nf_q       <= 3'h7;
      rx_state_q <= ASFS_IDLE;
      rx_cnt_q   <= '0;
      rx_k_q     <= '0;
    end else if (ce) begin
      if (tick) nf_q <= {nf_q[1:0], rxd};
      rx_state_q <= rx_state_d;
      if (rx_state_d != rx_state_q) rx_cnt_q <= '0;
      else if (tick) rx_cnt_q <= rx_sample ? '0 : rx_cnt_q + 5'h1;
      if (rx_state_d != rx_state_q) rx_k_q <= '0;
      else if (rx_sample) rx_k_q <= rx_k_q + 4'h1;
    end
  end

  // data capture apart from framing; stale data bits cleared while idle, parity and mp bits held
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_data_q <= '0;
      rx_par_q  <= 1'b0;
      rx_mp_q   <= 1'b0;
      rx_high_q <= 1'b0;
    end else if (ce) begin
      if (rx_state_q == ASFS_IDLE) begin
        rx_data_q <= '0;
        rx_high_q <= 1'b0;
      end else if (rx_sample && rx_state_q != ASFS_STOP) begin
        rx_high_q <= rx_high_q | rx_in;
      end
      if (rx_sample && rx_state_q == ASFS_DATA) begin
        rx_data_q[bit_index(cfg_q, rx_k_q)] <= rx_in ^ cfg_q.data_invert;
      end
      if (rx_sample && rx_state_q == ASFS_PARITY) rx_par_q <= rx_in ^ cfg_q.data_invert;
      if (rx_sample && rx_state_q == ASFS_MPB) rx_mp_q <= rx_in;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hold_q    <= 1'b0;
      rx_word_q <= '0;
    end else if (ce) begin
      hold_q <= rx_store | (hold_q & ~rx_pop);
      if (rx_store) rx_word_q <= '{mp_bit: rx_mp_q, data: rx_data_q};
    end
  end

  assign rx_valid = hold_q;
  assign rx_word  = rx_word_q;

  // status flags: a clear needs a prior read while set; a set always wins
  logic [ASFS_FLG_W-1:0] flags_q;
  logic [ASFS_FLG_W-1:0] seen_q;
  logic [ASFS_FLG_W-1:0] flag_set;
  logic [ASFS_FLG_W-1:0] flag_clr;

  assign flag_set[ASFS_FLG_RXERR]   = rx_done && (rx_perr || rx_ferr);
  assign flag_set[ASFS_FLG_READY]   = rx_store;
  assign flag_set[ASFS_FLG_BREAK]   = rx_done && rx_ferr && !rx_high_q;
  assign flag_set[ASFS_FLG_OVERRUN] = rx_done && !rx_store;
  assign flag_clr = flag_write ? (~flag_wdata & seen_q) : '0;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flags_q <= '0;
      seen_q  <= '0;
    end else if (ce) begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
      seen_q  <= (seen_q & ~flag_clr) | (flag_read ? flags_q : '0);
    end
  end

  assign flags = flags_q;
endmodule
`default_nettype wire

/* File: testbench/asfs_serial_properties.sv */
`default_nettype none
module asfs_serial_properties
  import asfs_pkg::*;
(
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rstn,
  // setup
  input wire logic                  cfg_load,
  input wire asfs_cfg_t             cfg_in,
  input wire logic                  transmit_enable,
  input wire asfs_cfg_t             cfg_active,
  input wire logic                  divisor_settled,
  input wire logic                  mode_unsupported,
  // receive and flags
  input wire logic                  rx_valid,
  input wire logic                  rx_ready,
  input wire asfs_word_t            rx_word,
  input wire logic                  flag_read,
  input wire logic                  flag_write,
  input wire logic [ASFS_FLG_W-1:0] flag_wdata,
  input wire logic [ASFS_FLG_W-1:0] flags,
  // pins
  input wire logic                  txd,
  input wire logic                  serial_clock_pin_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  int                    tick_raw;
  int                    tick_len;
  int                    bit_len;
  int                    low_q;
  logic                  bad_mode;
  logic [ASFS_FLG_W-1:0] rd_q;
  logic [ASFS_FLG_W-1:0] prev_q;
  logic [ASFS_FLG_W-1:0] fallen;

  assign tick_raw = (int'(cfg_active.bit_rate_divisor) + 1) << (2 * cfg_active.prescale_select);
  // halved rate floors at one clock
  assign tick_len = cfg_active.generator_double_speed ? ((tick_raw > 1) ? tick_raw / 2 : 1)
                                                      : tick_raw;
  assign bit_len  = tick_len * (cfg_active.oversample_select ? 8 : 16);
  assign bad_mode = cfg_active.sync_select | cfg_active.card_interface_select |
                    cfg_active.simple_two_wire_mode | cfg_active.clock_enable_sel[1];

  // low run length of the line, for frame size
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) low_q <= 0;
    else low_q <= txd ? 0 : low_q + 1;
  end

  // flags seen set by a read and still set
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) rd_q <= '0;
    else rd_q <= (rd_q & flags) | (flag_read ? flags : '0);
  end

  // flags one cycle ago, to see which fell
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) prev_q <= '0;
    else prev_q <= flags;
  end

  sequence s_bad_mode;
    bad_mode ##1 bad_mode;
  endsequence

  a_idle_mark: assert property (!transmit_enable |=> txd)
    else $error("txd left mark while transmit disabled");
  a_sck_free: assert property (cfg_active.clock_enable_sel == ASFS_CKE_INTERNAL
                |=> !serial_clock_pin_oe)
    else $error("serial clock pin driven under internal clock");
  a_settle_drop: assert property (cfg_load |=> !divisor_settled)
    else $error("settled flag stayed up after setup load");
  a_cfg_take: assert property (cfg_load |=> cfg_active == $past(cfg_in))
    else $error("setup word not taken");
  a_frame_len: assert property ($rose(txd) |-> low_q <= 9 * bit_len + tick_len)
    else $error("low run longer than start plus eight data bits");
  a_tx_settled: assert property ($fell(txd) |-> $past(divisor_settled))
    else $error("frame started before rate settled");
  a_mode_idle: assert property (s_bad_mode |-> mode_unsupported && !serial_clock_pin_oe)
    else $error("unsupported mode not flagged");
  a_flag_clear: assert property ((fallen != '0) |-> $past(flag_write) &&
                  ((fallen & ~($past(rd_q) & ~$past(flag_wdata))) == '0))
    else $error("flag cleared without read then zero write");
  a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_word))
    else $error("received word dropped before pop");

  assign fallen = prev_q & ~flags;
endmodule

bind asfs_serial asfs_serial_properties u_props (
  .ref_clk(ref_clk), .rstn(rstn), .cfg_load(cfg_load), .cfg_in(cfg_in),
  .transmit_enable(transmit_enable), .cfg_active(cfg_active),
  .divisor_settled(divisor_settled), .mode_unsupported(mode_unsupported),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word), .flag_read(flag_read),
  .flag_write(flag_write), .flag_wdata(flag_wdata), .flags(flags), .txd(txd),
  .serial_clock_pin_oe(serial_clock_pin_oe)
);
`default_nettype wire

/* File: testbench/asfs_remote_model.sv */
`default_nettype none
module asfs_remote_model #(
  parameter int BIT = 16
) (
  // clock
  input  wire logic ref_clk,
  // serial lines
  input  wire logic line_in,
  output logic      line_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] got[$];
  logic [7:0] sh;
  int         bad_stop;

  initial begin
    line_out = 1'b1;
    bad_stop = 0;
  end

  // samples mid-bit; a drifting rate misplaces later bits
  always begin
    @(posedge ref_clk);
    if (line_in === 1'b0) begin
      repeat (BIT / 2) @(posedge ref_clk);
      if (line_in === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(posedge ref_clk);
          sh[i] = line_in;
        end
        repeat (BIT) @(posedge ref_clk);
        if (line_in !== 1'b1) bad_stop++;
        got.push_back(sh);
      end
    end
  end

  // lsb first, one stop bit, line back at mark after
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      #1 line_out = f[i];
      repeat (BIT - 1) @(posedge ref_clk);
    end
    // hand back off the edge so the caller never races the design
    #1;
  endtask
endmodule
`default_nettype wire

/* File: testbench/asfs_serial_tb.sv */
`default_nettype none
module asfs_serial_tb
  import asfs_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  // divisor 1: two clocks a tick, eight ticks a bit
  localparam int BIT = 16;

  logic       ref_clk, rstn, ce, cfg_load, transmit_enable, receive_enable;
  logic       divisor_settled, mode_unsupported, tx_valid, tx_ready, rx_valid, rx_ready;
  logic       flag_read, flag_write, txd, rxd, sck_o, sck_oe;
  asfs_cfg_t  cfg_in, cfg_active;
  asfs_word_t tx_word, rx_word;
  logic [3:0] flag_wdata, flags;
  int         errors, n_checks;

  asfs_serial dut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .cfg_load(cfg_load),
    .cfg_in(cfg_in), .transmit_enable(transmit_enable), .receive_enable(receive_enable),
    .cfg_active(cfg_active), .divisor_settled(divisor_settled),
    .mode_unsupported(mode_unsupported), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_word(tx_word), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word),
    .flag_read(flag_read), .flag_write(flag_write), .flag_wdata(flag_wdata), .flags(flags),
    .txd(txd), .rxd(rxd), .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe));

  asfs_remote_model #(.BIT(BIT)) remote (.ref_clk(ref_clk), .line_in(txd), .line_out(rxd));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic complete_run;
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // drive point sits just after the edge
  task automatic tick_n(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic timed_out(input int n, input int lim);
    if (n >= lim) begin
      chk("wait bound", 32'(n), 32'(lim - 1));
      complete_run();
    end
  endtask

  task automatic t_reset;
    chk("reset setup", 32'(cfg_active), 32'(ASFS_CFG_RST));
    chk("idle txd", 32'(txd), 32'h1);
    chk("sck oe", 32'(sck_oe), 32'h0);
    chk("flags", 32'(flags), 32'h0);
  endtask

  task automatic t_modes;
    asfs_cfg_t c;
    int        n;
    for (int k = 0; k < 4; k++) begin
      c = ASFS_CFG_RST;
      c.bit_rate_divisor = 8'h01;
      c.sync_select = (k == 0);
      c.card_interface_select = (k == 1);
      if (k == 2) c.clock_enable_sel = ASFS_CKE_CLKOUT;
      cfg_in = c;
      cfg_load = 1'b1;
      tick_n(1);
      cfg_load = 1'b0;
      tick_n(2);
      chk("unsupported", 32'(mode_unsupported), 32'(k < 2));
      chk("sck oe mode", 32'(sck_oe), 32'(k == 2));
      if (k == 2) begin
        n = 0;
        repeat (BIT) begin
          n += int'(sck_o);
          tick_n(1);
        end
        chk("sck duty", 32'(n), 32'(BIT / 2));
      end
    end
    chk("active setup", 32'(cfg_active), 32'(c));
    n = 0;
    while (divisor_settled !== 1'b1 && n < 200) begin
      tick_n(1);
      n++;
    end
    timed_out(n, 200);
    chk("settle wait", 32'(n >= BIT - 3), 32'h1);
  endtask

  task automatic t_fifo_tx;
    int n;
    n = 0;
    transmit_enable = 1'b0;
    // top data bit and mp bit set: both must be ignored in this format
    while (tx_ready === 1'b1 && n < 20) begin
      tx_word = '{mp_bit: 1'b1, data: {1'b1, 8'h11 * n[7:0]}};
      tx_valid = 1'b1;
      tick_n(1);
      n++;
    end
    tx_valid = 1'b0;
    chk("fifo fill", 32'(n), 32'd16);
    chk("full refuses", 32'(tx_ready), 32'h0);
    tick_n(3 * BIT);
    chk("mark while off", 32'(txd), 32'h1);
    chk("no frames", 32'(remote.got.size()), 32'h0);
    transmit_enable = 1'b1;
    n = 0;
    while (remote.got.size() < 16 && n < 4000) begin
      tick_n(1);
      n++;
    end
    timed_out(n, 4000);
    for (int i = 0; i < 16; i++) begin
      chk("tx byte", 32'(remote.got[i]), 32'(8'h11 * i[7:0]));
    end
    chk("stop bits", 32'(remote.bad_stop), 32'h0);
    chk("drained", 32'(tx_ready), 32'h1);
  endtask

  task automatic wait_flag(input int bit_no);
    int n;
    n = 0;
    while (flags[bit_no] !== 1'b1 && n < 400) begin
      tick_n(1);
      n++;
    end
    timed_out(n, 400);
  endtask

  task automatic t_rx_overrun;
    receive_enable = 1'b1;
    rx_ready = 1'b0;
    remote.send(8'h3C);
    wait_flag(ASFS_FLG_READY);
    chk("rx data", 32'(rx_word.data), 32'h03C);
    chk("rx mp", 32'(rx_word.mp_bit), 32'h0);
    chk("rx error", 32'(flags[ASFS_FLG_RXERR]), 32'h0);
    remote.send(8'hC3);
    wait_flag(ASFS_FLG_OVERRUN);
    chk("kept word", 32'(rx_word.data), 32'h03C);
    // zero write before any read must not clear
    flag_wdata = 4'h0;
    flag_write = 1'b1;
    tick_n(1);
    flag_write = 1'b0;
    tick_n(1);
    chk("unread overrun", 32'(flags[ASFS_FLG_OVERRUN]), 32'h1);
    flag_read = 1'b1;
    tick_n(1);
    flag_read = 1'b0;
    flag_write = 1'b1;
    tick_n(1);
    flag_write = 1'b0;
    tick_n(1);
    chk("cleared overrun", 32'(flags[ASFS_FLG_OVERRUN]), 32'h0);
    rx_ready = 1'b1;
    tick_n(1);
    rx_ready = 1'b0;
    tick_n(1);
    chk("popped", 32'(rx_valid), 32'h0);
  endtask

  initial begin
    errors = 0;
    n_checks = 0;
    rstn = 1'b0;
    ce = 1'b1;
    cfg_load = 1'b0;
    cfg_in = ASFS_CFG_RST;
    transmit_enable = 1'b0;
    receive_enable = 1'b0;
    tx_valid = 1'b0;
    tx_word = '0;
    rx_ready = 1'b0;
    flag_read = 1'b0;
    flag_write = 1'b0;
    flag_wdata = 4'h0;
    tick_n(16);
    rstn = 1'b1;
    tick_n(1);
    t_reset();
    t_modes();
    t_fifo_tx();
    t_rx_overrun();
    complete_run();
  end
endmodule
`default_nettype wire
